// >>> logic/sme_core.sv
// Purpose: executes shift, move and indirect-load instructions written over Avalon-MM
// Assumes: one bus access at a time; instructions complete in the accept cycle
// Notes: data memory is linear, indexed by the low MEM_AW address bits
// Notes on behaviour
// - right shift: bits 7:1 down, zero in, carry out
// - destination bit picks accumulator or file register
// - indirect load copies pointed byte, updates zero
// - indirect locations redirect through their file pointer
// - mode 00/01/10/11 pre-inc, pre-dec, post-inc, post-dec
// - pointer ends one above or below old
// - relative form adds signed offset, pointer unchanged
// - pointer is 16 bits and wraps
// - bank literal load leaves flags alone
// - 7-bit program latch literal load, flags kept
// - 8-bit accumulator literal, flags kept, spare bits zero
// - accumulator store to 7-bit file address, flags kept
`timescale 1ns/1ps
module sme_core #(
  parameter int unsigned MEM_AW = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == 8'h00);
  endfunction

  function automatic logic [31:0] be_merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0] be
  );
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    be_merge = r;
  endfunction

  // high literal bits above the field must be clear
  function automatic logic spare_clear(
    input logic [11:0] body,
    input int unsigned w
  );
    spare_clear = ((body >> w) == 12'h000);
  endfunction

  // direct address, or the pointer for an indirect location
  function automatic logic [15:0] file_addr(
    input logic [6:0] f,
    input logic [4:0] bank,
    input logic [15:0] p0,
    input logic [15:0] p1
  );
    if (f == sme_pkg::IND_LOC0) begin
      file_addr = p0;
    end else if (f == sme_pkg::IND_LOC1) begin
      file_addr = p1;
    end else begin
      file_addr = {4'h0, bank, f};
    end
  endfunction

  // word returned for a register read; unmapped offsets read zero
  function automatic logic [31:0] read_word(
    input logic [5:0] ad,
    input sme_pkg::sme_state_t s,
    input logic [31:0] stw,
    input logic [7:0] mem_byte
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    if (ad == sme_pkg::OFS_INSTR) begin
      w = {16'h0000, s.last_instr};
    end else if (ad == sme_pkg::OFS_ACC) begin
      w = {24'h000000, s.acc};
    end else if (ad == sme_pkg::OFS_STATUS) begin
      w = stw;
    end else if (ad == sme_pkg::OFS_BANK) begin
      w = {27'h0000000, s.bank_select_reg};
    end else if (ad == sme_pkg::OFS_PCLATCH) begin
      w = {25'h0000000, s.pc_high_latch};
    end else if (ad == sme_pkg::OFS_FPTR0) begin
      w = {16'h0000, s.file_pointer0};
    end else if (ad == sme_pkg::OFS_FPTR1) begin
      w = {16'h0000, s.file_pointer1};
    end else if (ad == sme_pkg::OFS_MEM_ADDR) begin
      w = {16'h0000, s.mem_addr};
    end else if (ad == sme_pkg::OFS_MEM_DATA) begin
      w = {24'h000000, mem_byte};
    end else if (ad == sme_pkg::OFS_EXEC_CNT) begin
      w = {16'h0000, s.exec_cnt};
    end
    read_word = w;
  endfunction

  // ---------------------------------------------------------------
  // state and memory
  // ---------------------------------------------------------------
  sme_pkg::sme_state_t st_ff;
  sme_pkg::sme_state_t nxt_st;
  logic [7:0] mem [0:(2**MEM_AW)-1];

  logic mem_we;
  logic [MEM_AW-1:0] mem_wa;
  logic [7:0] mem_wd;

  logic req;
  logic accept;
  logic wr_accept;
  logic [15:0] instr;
  logic [3:0] opc;
  logic [6:0] fld_file;
  logic [15:0] fa;
  logic [7:0] file_rd;
  logic [7:0] ind_rd;
  logic [7:0] win_rd;
  logic [7:0] shift_res;
  logic [15:0] sel_ptr;
  logic [31:0] status_word;
  sme_pkg::sme_ptr_t ptr_res;
  logic dest_file;
  logic ptr_sel1;
  logic rel_form;
  logic [1:0] upd_mode;
  logic [5:0] rel_offs;
  logic [MEM_AW-1:0] file_idx;
  logic [MEM_AW-1:0] ind_idx;
  logic [MEM_AW-1:0] win_idx;
  logic shift_carry;
  logic shift_zero;

  assign req = avs_read | avs_write;
  assign accept = req & ~st_ff.wait_req;
  assign wr_accept = accept & avs_write;
  assign instr = avs_writedata[15:0];

  // ---------------------------------------------------------------
  // instruction field decode
  // ---------------------------------------------------------------
  assign opc = instr[sme_pkg::OP_HI:sme_pkg::OP_LO];
  assign fld_file = instr[sme_pkg::FILE_W-1:0];
  assign dest_file = instr[sme_pkg::FLD_DEST];
  assign ptr_sel1 = instr[sme_pkg::FLD_PTR_SEL];
  assign rel_form = instr[sme_pkg::FLD_REL];
  assign upd_mode = instr[1:0];
  assign rel_offs = instr[sme_pkg::OFFS_W-1:0];
  assign sel_ptr = ptr_sel1 ? st_ff.file_pointer1 : st_ff.file_pointer0;

  sme_ptr_calc u_ptr (
    .ptr (sel_ptr),
    .mode (upd_mode),
    .rel (rel_form),
    .offs (rel_offs),
    .res (ptr_res)
  );

  // ---------------------------------------------------------------
  // data memory read ports
  // ---------------------------------------------------------------
  // every address folds onto the low MEM_AW bits of the memory
  assign fa = file_addr(fld_file, st_ff.bank_select_reg, st_ff.file_pointer0, st_ff.file_pointer1);
  assign file_idx = fa[MEM_AW-1:0];
  assign ind_idx = ptr_res.eff_addr[MEM_AW-1:0];
  assign win_idx = st_ff.mem_addr[MEM_AW-1:0];
  assign file_rd = mem[file_idx];
  assign ind_rd = mem[ind_idx];
  assign win_rd = mem[win_idx];
  assign shift_res = {1'b0, file_rd[7:1]};
  assign shift_carry = file_rd[0];
  assign shift_zero = is_zero(shift_res);

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[sme_pkg::ST_CARRY] = st_ff.carry;
    status_word[sme_pkg::ST_ZERO] = st_ff.zero;
    status_word[sme_pkg::ST_ILLEGAL] = st_ff.illegal;
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [31:0] m;
    m = 32'h0000_0000;
    nxt_st = st_ff;
    mem_we = 1'b0;
    mem_wa = fa[MEM_AW-1:0];
    mem_wd = st_ff.acc;

    // bus handshake: one wait cycle, then accept
    // read data latched in the wait cycle, stands through the accept cycle
    if (req && st_ff.wait_req) begin
      nxt_st.wait_req = 1'b0;
      nxt_st.rdata = read_word(avs_address, st_ff, status_word, win_rd);
    end else if (accept) begin
      nxt_st.wait_req = 1'b1;
    end

    // register writes take effect at the accepting edge
    if (wr_accept) begin
      if (avs_address == sme_pkg::OFS_INSTR) begin
        nxt_st.last_instr = instr;
        nxt_st.exec_cnt = 16'(st_ff.exec_cnt + 16'h0001);
        case (opc)
          sme_pkg::OPC_NOP: begin
          end
          sme_pkg::OPC_LSR: begin
            nxt_st.carry = shift_carry;
            nxt_st.zero = shift_zero;
            if (dest_file) begin
              mem_we = 1'b1;
              mem_wa = file_idx;
              mem_wd = shift_res;
            end else begin
              nxt_st.acc = shift_res;
            end
          end
          sme_pkg::OPC_IND_LOAD: begin
            nxt_st.acc = ind_rd;
            nxt_st.zero = is_zero(ind_rd);
            // pointer update leaves carry untouched
            if (ptr_sel1) begin
              nxt_st.file_pointer1 = ptr_res.ptr_next;
            end else begin
              nxt_st.file_pointer0 = ptr_res.ptr_next;
            end
          end
          sme_pkg::OPC_BANK_LIT: begin
            if (spare_clear(instr[11:0], sme_pkg::BANK_W)) begin
              nxt_st.bank_select_reg = instr[sme_pkg::BANK_W-1:0];
            end else begin
              nxt_st.illegal = 1'b1;
            end
          end
          sme_pkg::OPC_PCL_LIT: begin
            if (spare_clear(instr[11:0], sme_pkg::PCL_W)) begin
              nxt_st.pc_high_latch = instr[sme_pkg::PCL_W-1:0];
            end else begin
              nxt_st.illegal = 1'b1;
            end
          end
          sme_pkg::OPC_ACC_LIT: begin
            if (spare_clear(instr[11:0], sme_pkg::LIT_W)) begin
              nxt_st.acc = instr[sme_pkg::LIT_W-1:0];
            end else begin
              nxt_st.illegal = 1'b1;
            end
          end
          sme_pkg::OPC_ACC_STORE: begin
            if (spare_clear(instr[11:0], sme_pkg::FILE_W)) begin
              mem_we = 1'b1;
              mem_wa = fa[MEM_AW-1:0];
              mem_wd = st_ff.acc;
            end else begin
              nxt_st.illegal = 1'b1;
            end
          end
          default: begin
            nxt_st.illegal = 1'b1;
          end
        endcase
      end else if (avs_address == sme_pkg::OFS_ACC) begin
        m = be_merge({24'h000000, st_ff.acc}, avs_writedata, avs_byteenable);
        nxt_st.acc = m[7:0];
      end else if (avs_address == sme_pkg::OFS_STATUS) begin
        if (avs_byteenable[0]) begin
          nxt_st.carry = avs_writedata[sme_pkg::ST_CARRY];
          nxt_st.zero = avs_writedata[sme_pkg::ST_ZERO];
          // write one clears the illegal flag
          if (avs_writedata[sme_pkg::ST_ILLEGAL]) begin
            nxt_st.illegal = 1'b0;
          end
        end
      end else if (avs_address == sme_pkg::OFS_BANK) begin
        m = be_merge({27'h0000000, st_ff.bank_select_reg}, avs_writedata, avs_byteenable);
        nxt_st.bank_select_reg = m[4:0];
      end else if (avs_address == sme_pkg::OFS_PCLATCH) begin
        m = be_merge({25'h0000000, st_ff.pc_high_latch}, avs_writedata, avs_byteenable);
        nxt_st.pc_high_latch = m[6:0];
      end else if (avs_address == sme_pkg::OFS_FPTR0) begin
        m = be_merge({16'h0000, st_ff.file_pointer0}, avs_writedata, avs_byteenable);
        nxt_st.file_pointer0 = m[15:0];
      end else if (avs_address == sme_pkg::OFS_FPTR1) begin
        m = be_merge({16'h0000, st_ff.file_pointer1}, avs_writedata, avs_byteenable);
        nxt_st.file_pointer1 = m[15:0];
      end else if (avs_address == sme_pkg::OFS_MEM_ADDR) begin
        m = be_merge({16'h0000, st_ff.mem_addr}, avs_writedata, avs_byteenable);
        nxt_st.mem_addr = m[15:0];
      end else if (avs_address == sme_pkg::OFS_MEM_DATA) begin
        if (avs_byteenable[0]) begin
          mem_we = 1'b1;
          mem_wa = st_ff.mem_addr[MEM_AW-1:0];
          mem_wd = avs_writedata[7:0];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff.wait_req <= 1'b1;
      st_ff.rdata <= 32'h0000_0000;
      st_ff.last_instr <= 16'h0000;
      st_ff.acc <= sme_pkg::RST_ACC;
      st_ff.carry <= 1'b0;
      st_ff.zero <= 1'b0;
      st_ff.illegal <= 1'b0;
      st_ff.bank_select_reg <= sme_pkg::RST_BANK;
      st_ff.pc_high_latch <= sme_pkg::RST_PCL;
      st_ff.file_pointer0 <= sme_pkg::RST_FPTR;
      st_ff.file_pointer1 <= sme_pkg::RST_FPTR;
      st_ff.mem_addr <= 16'h0000;
      st_ff.exec_cnt <= 16'h0000;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // memory has no reset
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // ---------------------------------------------------------------
  // bus outputs, straight from the state register
  // ---------------------------------------------------------------
  assign avs_readdata = st_ff.rdata;
  assign avs_waitrequest = st_ff.wait_req;

endmodule

// >>> logic/sme_ptr_calc.sv
// Purpose: effective address and next value of a file pointer
// Assumes: 16-bit pointer, 6-bit signed relative offset
// Notes: purely combinational
`timescale 1ns/1ps
module sme_ptr_calc (
  input wire logic [15:0] ptr,
  input wire logic [1:0] mode,
  input wire logic rel,
  input wire logic [5:0] offs,
  output sme_pkg::sme_ptr_t res
);

  logic [15:0] inc;
  logic [15:0] dec;
  logic [15:0] offs_ext;

  // ---------------------------------------------------------------
  // arithmetic wraps modulo 65536
  // ---------------------------------------------------------------
  always_comb begin
    inc = 16'(ptr + 16'h0001);
    dec = 16'(ptr - 16'h0001);
    offs_ext = {{10{offs[5]}}, offs};
    res.eff_addr = ptr;
    res.ptr_next = ptr;
    if (rel) begin
      res.eff_addr = 16'(ptr + offs_ext);
      res.ptr_next = ptr;
    end else begin
      case (mode)
        sme_pkg::PM_PRE_INC: begin
          res.eff_addr = inc;
          res.ptr_next = inc;
        end
        sme_pkg::PM_PRE_DEC: begin
          res.eff_addr = dec;
          res.ptr_next = dec;
        end
        sme_pkg::PM_POST_INC: begin
          res.eff_addr = ptr;
          res.ptr_next = inc;
        end
        default: begin
          res.eff_addr = ptr;
          res.ptr_next = dec;
        end
      endcase
    end
  end

endmodule

// >>> shared/sme_pkg.sv
// Purpose: shared constants and types of the shift/move/indirect executor
// Assumes: 32-bit Avalon-MM slave, byte addresses, one aligned word per register
// Notes: instruction word layout is local to this block
package sme_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam int unsigned BUS_AW = 6;
  localparam logic [5:0] OFS_INSTR = 6'h00;
  localparam logic [5:0] OFS_ACC = 6'h04;
  localparam logic [5:0] OFS_STATUS = 6'h08;
  localparam logic [5:0] OFS_BANK = 6'h0c;
  localparam logic [5:0] OFS_PCLATCH = 6'h10;
  localparam logic [5:0] OFS_FPTR0 = 6'h14;
  localparam logic [5:0] OFS_FPTR1 = 6'h18;
  localparam logic [5:0] OFS_MEM_ADDR = 6'h1c;
  localparam logic [5:0] OFS_MEM_DATA = 6'h20;
  localparam logic [5:0] OFS_EXEC_CNT = 6'h24;

  // ---------------------------------------------------------------
  // status register bits
  // ---------------------------------------------------------------
  localparam int unsigned ST_CARRY = 0;
  localparam int unsigned ST_ZERO = 1;
  localparam int unsigned ST_ILLEGAL = 2;

  // ---------------------------------------------------------------
  // instruction word fields
  // ---------------------------------------------------------------
  localparam int unsigned OP_HI = 15;
  localparam int unsigned OP_LO = 12;
  localparam int unsigned FLD_DEST = 7;
  localparam int unsigned FLD_PTR_SEL = 8;
  localparam int unsigned FLD_REL = 7;
  localparam int unsigned FILE_W = 7;
  localparam int unsigned BANK_W = 5;
  localparam int unsigned PCL_W = 7;
  localparam int unsigned LIT_W = 8;
  localparam int unsigned OFFS_W = 6;
  localparam int unsigned FPTR_W = 16;

  localparam logic [3:0] OPC_NOP = 4'h0;
  localparam logic [3:0] OPC_LSR = 4'h1;
  localparam logic [3:0] OPC_IND_LOAD = 4'h2;
  localparam logic [3:0] OPC_BANK_LIT = 4'h3;
  localparam logic [3:0] OPC_PCL_LIT = 4'h4;
  localparam logic [3:0] OPC_ACC_LIT = 4'h5;
  localparam logic [3:0] OPC_ACC_STORE = 4'h6;

  // file addresses that redirect through a pointer
  localparam logic [6:0] IND_LOC0 = 7'h00;
  localparam logic [6:0] IND_LOC1 = 7'h01;

  // pointer update modes
  localparam logic [1:0] PM_PRE_INC = 2'h0;
  localparam logic [1:0] PM_PRE_DEC = 2'h1;
  localparam logic [1:0] PM_POST_INC = 2'h2;
  localparam logic [1:0] PM_POST_DEC = 2'h3;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_ACC = 8'h00;
  localparam logic [4:0] RST_BANK = 5'h00;
  localparam logic [6:0] RST_PCL = 7'h00;
  localparam logic [15:0] RST_FPTR = 16'h0000;

  typedef struct packed {
    logic [15:0] eff_addr;
    logic [15:0] ptr_next;
  } sme_ptr_t;

  typedef struct packed {
    logic wait_req;
    logic [31:0] rdata;
    logic [15:0] last_instr;
    logic [7:0] acc;
    logic carry;
    logic zero;
    logic illegal;
    logic [4:0] bank_select_reg;
    logic [6:0] pc_high_latch;
    logic [15:0] file_pointer0;
    logic [15:0] file_pointer1;
    logic [15:0] mem_addr;
    logic [15:0] exec_cnt;
  } sme_state_t;

endpackage

// >>> sim/sme_core_monitor.sv
// Purpose: bus timing and readback checks for sme_core
// Assumes: one bus request at a time, byteenable all ones for instructions
// Notes: literal echo is tracked from accepted instruction writes
`timescale 1ns/1ps
module sme_core_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  // ---------------------------------------------------------------
  // literal tracking
  // ---------------------------------------------------------------
  logic lit_vld_ff;
  logic [5:0] lit_ofs_ff;
  logic [7:0] lit_val_ff;
  logic [3:0] op;
  logic lit_ok;
  logic [5:0] nxt_ofs;
  logic [7:0] nxt_val;
  assign op = avs_writedata[15:12];
  assign lit_ok = (op == sme_pkg::OPC_BANK_LIT && avs_writedata[11:5] == 7'h00)
    || (op == sme_pkg::OPC_PCL_LIT && avs_writedata[11:7] == 5'h00)
    || (op == sme_pkg::OPC_ACC_LIT && avs_writedata[11:8] == 4'h0);
  assign nxt_ofs = (op == sme_pkg::OPC_BANK_LIT) ? sme_pkg::OFS_BANK
    : (op == sme_pkg::OPC_PCL_LIT) ? sme_pkg::OFS_PCLATCH : sme_pkg::OFS_ACC;
  assign nxt_val = (op == sme_pkg::OPC_BANK_LIT) ? {3'h0, avs_writedata[4:0]}
    : (op == sme_pkg::OPC_PCL_LIT) ? {1'h0, avs_writedata[6:0]} : avs_writedata[7:0];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lit_vld_ff <= 1'b0;
      lit_ofs_ff <= 6'h00;
      lit_val_ff <= 8'h00;
    end else if (avs_write && !avs_waitrequest) begin
      lit_vld_ff <= lit_ok && avs_address == sme_pkg::OFS_INSTR && avs_byteenable == 4'hf;
      lit_ofs_ff <= nxt_ofs;
      lit_val_ff <= nxt_val;
    end
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_rd(logic [5:0] o);
    avs_read && !avs_waitrequest && avs_address == o;
  endsequence
  a_wait_one: assert property (s_req |=> !avs_waitrequest) else $error("request not accepted after one wait");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("accept longer than one cycle");
  a_idle_wait: assert property (!(avs_read || avs_write) |=> avs_waitrequest) else $error("accept with no request");
  a_acc_width: assert property (s_rd(sme_pkg::OFS_ACC) |-> avs_readdata[31:8] == 24'h0) else $error("acc too wide");
  a_bank_width: assert property (s_rd(sme_pkg::OFS_BANK) |-> avs_readdata[31:5] == 27'h0) else $error("bank too wide");
  a_latch_width: assert property (s_rd(sme_pkg::OFS_PCLATCH) |-> avs_readdata[31:7] == 25'h0) else $error("latch wide");
  a_ptr_width: assert property (s_rd(sme_pkg::OFS_FPTR1) |-> avs_readdata[31:16] == 16'h0) else $error("pointer wide");
  a_lit_echo: assert property (lit_vld_ff ##0 s_rd(lit_ofs_ff) |-> avs_readdata[7:0] == lit_val_ff)
    else $error("literal not loaded");
endmodule

bind sme_core sme_core_monitor u_mon (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

// >>> sim/sme_core_tb.sv
// Purpose: self-checking bench for sme_core
// Assumes: MEM_AW of 8, bank zero for direct file accesses
// Notes: memory is filled with index xor 5a before indirect loads
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module sme_core_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  int fails = 0;
  int check_count = 0;
  int seed = 32'h0bfff810;
  logic [31:0] rd;
  logic [15:0] p, a;
  logic [7:0] v;
  logic [6:0] f;
  logic [5:0] k;
  logic [1:0] m;
  logic r, s, d;
  sme_pkg::sme_ptr_t e;
  logic [5:0] ofs_tab [8] = '{6'h04, 6'h08, 6'h0c, 6'h10, 6'h14, 6'h18, 6'h24, 6'h3c};
  always #20 clk = ~clk;
  sme_core #(.MEM_AW(8)) DUT (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  // ---------------------------------------------------------------
  // bus tasks and expectations
  // ---------------------------------------------------------------
  task automatic bus(input logic w, input logic [5:0] ad, input logic [31:0] dt);
    @(posedge clk);
    avs_address <= ad;
    avs_writedata <= dt;
    avs_read <= !w;
    avs_write <= w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] ad, input logic [31:0] dt);
    bus(1'b1, ad, dt);
  endtask
  task automatic rdr(input logic [5:0] ad);
    bus(1'b0, ad, 32'h0);
  endtask
  task automatic rdm(input logic [15:0] ad);
    wr(sme_pkg::OFS_MEM_ADDR, {16'h0, ad});
    rdr(sme_pkg::OFS_MEM_DATA);
  endtask
  function automatic logic [7:0] fill(input logic [7:0] i);
    return i ^ 8'h5a;
  endfunction
  function automatic sme_pkg::sme_ptr_t ptr_exp(input logic [15:0] pp, input logic [1:0] mm, input logic rr,
                                                input logic [5:0] kk);
    sme_pkg::sme_ptr_t x;
    x.ptr_next = rr ? pp : (mm[0] ? pp - 16'h1 : pp + 16'h1);
    x.eff_addr = rr ? pp + {{10{kk[5]}}, kk} : (mm[1] ? pp : x.ptr_next);
    return x;
  endfunction
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    complete_run();
  end
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    foreach (ofs_tab[i]) begin
      rdr(ofs_tab[i]);
      `CHK(rd, 32'h0)
    end
    $display("test reset done");
    wr(sme_pkg::OFS_STATUS, 32'h3);
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 8'hff : 8'($random(seed));
      wr(sme_pkg::OFS_INSTR, {20'h3, 7'h0, 1'b0, v[3:0]});
      rdr(sme_pkg::OFS_BANK);
      `CHK(rd, {28'h0, v[3:0]})
      wr(sme_pkg::OFS_INSTR, {20'h4, 5'h0, v[6:0]});
      rdr(sme_pkg::OFS_PCLATCH);
      `CHK(rd, {25'h0, v[6:0]})
      wr(sme_pkg::OFS_INSTR, {20'h5, 4'h0, v});
      rdr(sme_pkg::OFS_ACC);
      `CHK(rd, {24'h0, v})
      rdr(sme_pkg::OFS_STATUS);
      `CHK(rd, 32'h3)
    end
    wr(sme_pkg::OFS_INSTR, 32'h5800);
    rdr(sme_pkg::OFS_ACC);
    `CHK(rd, {24'h0, v})
    rdr(sme_pkg::OFS_STATUS);
    `CHK(rd, 32'h7)
    rdr(sme_pkg::OFS_INSTR);
    `CHK(rd, 32'h5800)
    wr(sme_pkg::OFS_INSTR, {20'h3, 12'h0});
    $display("test literals done");
    for (int i = 0; i < 256; i++) begin
      wr(sme_pkg::OFS_MEM_ADDR, i);
      wr(sme_pkg::OFS_MEM_DATA, {24'h0, fill(8'(i))});
    end
    for (int i = 0; i < 24; i++) begin
      p = (i < 4) ? {16{~i[0]}} : (i == 4) ? 16'h1259 : 16'($random(seed));
      m = 2'(i);
      r = (i >= 16);
      k = (i == 16) ? 6'h20 : (i == 17) ? 6'h1f : 6'($random(seed));
      s = i[2];
      wr(s ? sme_pkg::OFS_FPTR1 : sme_pkg::OFS_FPTR0, {16'h0, p});
      wr(sme_pkg::OFS_INSTR, {20'h2, 3'h0, s, r, r ? {1'b0, k} : {5'h0, m}});
      e = ptr_exp(p, m, r, k);
      rdr(sme_pkg::OFS_ACC);
      `CHK(rd, {24'h0, fill(e.eff_addr[7:0])})
      rdr(sme_pkg::OFS_STATUS);
      `CHK(rd[1], fill(e.eff_addr[7:0]) == 8'h0)
      rdr(s ? sme_pkg::OFS_FPTR1 : sme_pkg::OFS_FPTR0);
      `CHK(rd, {16'h0, e.ptr_next})
    end
    $display("test indirect done");
    wr(sme_pkg::OFS_STATUS, 32'h5);
    for (int i = 0; i < 6; i++) begin
      v = 8'($random(seed));
      p = 16'($random(seed));
      f = (i == 0) ? 7'h01 : (i == 1) ? 7'h7f : {1'b1, 6'($random(seed))};
      a = (f == 7'h01) ? p : {9'h0, f};
      wr(sme_pkg::OFS_FPTR1, {16'h0, p});
      wr(sme_pkg::OFS_INSTR, {20'h5, 4'h0, v});
      wr(sme_pkg::OFS_INSTR, {20'h6, 5'h0, f});
      rdm(a);
      `CHK(rd, {24'h0, v})
    end
    rdr(sme_pkg::OFS_STATUS);
    `CHK(rd, 32'h1)
    $display("test store done");
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 8'h01 : (i == 1) ? 8'h80 : 8'($random(seed));
      d = i[0];
      p = 16'($random(seed));
      f = i[1] ? 7'h00 : {1'b1, 6'($random(seed))};
      a = (f == 7'h00) ? p : {9'h0, f};
      wr(sme_pkg::OFS_FPTR0, {16'h0, p});
      wr(sme_pkg::OFS_MEM_ADDR, {16'h0, a});
      wr(sme_pkg::OFS_MEM_DATA, {24'h0, v});
      wr(sme_pkg::OFS_ACC, 32'h33);
      wr(sme_pkg::OFS_STATUS, {31'h0, ~v[0]});
      wr(sme_pkg::OFS_INSTR, {20'h1, 4'h0, d, f});
      rdm(a);
      `CHK(rd, {24'h0, d ? v >> 1 : v})
      rdr(sme_pkg::OFS_ACC);
      `CHK(rd, {24'h0, d ? 8'h33 : v >> 1})
      rdr(sme_pkg::OFS_STATUS);
      `CHK(rd, {30'h0, v[7:1] == 7'h0, v[0]})
    end
    $display("test shift done");
    complete_run();
  end
endmodule
